// >>> logic/charger_boost_supervisor.sv
// Charger and boost supervisor: mode decode, safety timer, fault flags,
// interrupt and status pins, behind an AXI4-Lite register slave.
// Assumes monitor inputs are clean levels synchronous to mclk.
`timescale 1ns/1ns
`include "supervisor_map.svh"

module charger_boost_supervisor #(
  parameter int TICK_CYCLES = `TICK_MS * `MCLK_KHZ
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // AXI4-Lite register slave
  input  wire supervisor_pkg::axi_req_s axi_req,
  output      supervisor_pkg::axi_rsp_s axi_rsp,
  // Analog monitor indications
  input  wire supervisor_pkg::sense_s   sense,
  // External boost request pin
  input  wire logic                     boost_request_pin,
  // Power path controls
  output      supervisor_pkg::power_s   power,
  // Open-drain pins, enable low while pulling low
  output      logic                     int_out,
  output      logic                     int_oe_n,
  output      logic                     stat_out,
  output      logic                     stat_oe_n
);
  import supervisor_pkg::*;

  // Prescaler counter is only TICK_W bits wide
  if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << `TICK_W)) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  localparam tick_t TICK_LAST  = tick_t'(TICK_CYCLES - 1);
  localparam ms_t   BOOST_LIM  = ms_t'(`BOOST_LIMIT_TICKS);
  localparam ms_t   CHARGE_LIM = ms_t'(`CHARGE_LIMIT_TICKS);
  localparam ms_t   MS_MAX     = '1;
  localparam cnt_t  SAG_LIM    = cnt_t'(`SAG_DELAY_TICKS);
  localparam cnt_t  OL_LIM     = cnt_t'(`OVERLOAD_TICKS);

  st_s  st_ff;
  st_s  nxt;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic b_hs;
  logic r_hs;

  // Channel handshakes
  assign aw_hs = axi_req.awvalid & st_ff.rsp.awready;
  assign w_hs  = axi_req.wvalid & st_ff.rsp.wready;
  assign ar_hs = axi_req.arvalid & st_ff.rsp.arready;
  assign b_hs  = axi_req.bready & st_ff.rsp.bvalid;
  assign r_hs  = axi_req.rready & st_ff.rsp.rvalid;

  // Next state of the whole block
  always_comb begin
    logic        do_wr;
    logic        bus_cmd;
    logic        acc_flt;
    logic        pin_req;
    logic        boost_now;
    logic [31:0] rd_val;
    logic [1:0]  rsp_v;
    logic [1:0]  e1;
    logic [3:0]  e2;
    logic [2:0]  e3;
    sense_s      rise;
    do_wr     = 1'b0;
    bus_cmd   = 1'b0;
    acc_flt   = 1'b0;
    rd_val    = 32'h0000_0000;
    rsp_v     = `RESP_OKAY;
    e1        = '0;
    e2        = '0;
    e3        = '0;
    rise      = sense_s'(sense & ~st_ff.sense_q);
    pin_req   = st_ff.cfg[`CFG_PIN_EN] &
                (boost_request_pin == st_ff.cfg[`CFG_PIN_POL]);
    boost_now = (st_ff.mode == MODE_BOOST);
    nxt       = st_ff;
    nxt.sense_q = sense;

    // Write address and data may arrive in either order
    if (aw_hs) begin
      nxt.aw_have = 1'b1;
      nxt.waddr   = axi_req.awaddr;
    end
    if (w_hs) begin
      nxt.w_have = 1'b1;
      nxt.wdata  = axi_req.wdata;
      nxt.wstrb  = axi_req.wstrb;
    end
    if (b_hs) begin
      nxt.rsp.bvalid = 1'b0;
    end
    do_wr = nxt.aw_have & nxt.w_have & ~nxt.rsp.bvalid;
    if (do_wr) begin
      nxt.aw_have    = 1'b0;
      nxt.w_have     = 1'b0;
      nxt.rsp.bvalid = 1'b1;
      nxt.rsp.bresp  = `RESP_OKAY;
      // All fields live in byte lane 0
      case (nxt.waddr)
        `OFS_CONTROL: begin
          if (nxt.wstrb[0]) begin
            nxt.mode      = op_mode_e'(nxt.wdata[`MODE_LSB +: 2]);
            nxt.stat_ctrl = nxt.wdata[`STAT_LSB +: 2];
            if (nxt.wdata[`MODE_LSB +: 2] == MODE_BOOST) begin
              nxt.ovp_lock = 1'b0;
            end
          end
        end
        `OFS_CONFIG: begin
          if (nxt.wstrb[0]) begin
            nxt.cfg = nxt.wdata[7:0];
          end
        end
        `OFS_FAULT1, `OFS_FAULT2, `OFS_FAULT3: begin
          acc_flt = 1'b1;
        end
        `OFS_MASK1: begin
          if (nxt.wstrb[0]) begin
            nxt.m1 = nxt.wdata[1:0];
          end
        end
        `OFS_MASK2: begin
          if (nxt.wstrb[0]) begin
            nxt.m2 = nxt.wdata[3:0];
          end
        end
        `OFS_MASK3: begin
          if (nxt.wstrb[0]) begin
            nxt.m3 = nxt.wdata[2:0];
          end
        end
        `OFS_STATE: begin
          nxt.rsp.bresp = `RESP_OKAY;
        end
        default: begin
          nxt.rsp.bresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt.rsp.awready = ~nxt.aw_have & ~nxt.rsp.bvalid;
    nxt.rsp.wready  = ~nxt.w_have & ~nxt.rsp.bvalid;

    // Reads; a fault register read clears what it returned
    if (r_hs) begin
      nxt.rsp.rvalid = 1'b0;
    end
    if (ar_hs) begin
      case (axi_req.araddr)
        `OFS_CONTROL: rd_val = 32'({st_ff.stat_ctrl, st_ff.mode});
        `OFS_CONFIG:  rd_val = 32'(st_ff.cfg);
        `OFS_FAULT1: begin
          rd_val  = 32'(st_ff.f1);
          nxt.f1  = '0;
          acc_flt = 1'b1;
        end
        `OFS_FAULT2: begin
          rd_val  = 32'(st_ff.f2);
          nxt.f2  = '0;
          acc_flt = 1'b1;
        end
        `OFS_FAULT3: begin
          rd_val  = 32'(st_ff.f3);
          nxt.f3  = '0;
          acc_flt = 1'b1;
        end
        `OFS_MASK1:   rd_val = 32'(st_ff.m1);
        `OFS_MASK2:   rd_val = 32'(st_ff.m2);
        `OFS_MASK3:   rd_val = 32'(st_ff.m3);
        `OFS_STATE:   rd_val = 32'({st_ff.therm_hold, st_ff.ovp_lock,
                                    st_ff.skip, st_ff.pwr});
        default:      rsp_v  = `RESP_SLVERR;
      endcase
      nxt.rsp.rvalid = 1'b1;
      nxt.rsp.rdata  = rd_val;
      nxt.rsp.rresp  = rsp_v;
    end
    nxt.rsp.arready = ~nxt.rsp.rvalid;
    bus_cmd = do_wr | ar_hs;

    // Millisecond tick from mclk
    nxt.tick = 1'b0;
    if (st_ff.tick_cnt == TICK_LAST) begin
      nxt.tick_cnt = '0;
      nxt.tick     = 1'b1;
    end else begin
      nxt.tick_cnt = st_ff.tick_cnt + 1'b1;
    end

    // Attach wins over a host write in the same cycle
    if (rise.source_valid) begin
      nxt.cfg[`CFG_REDUCED] = 1'b1;
    end

    // Boost pin acts only on a change of its request level
    nxt.pin_q = pin_req;
    if (pin_req && !st_ff.pin_q && !nxt.ovp_lock) begin
      nxt.mode = MODE_BOOST;
    end else if (!pin_req && st_ff.pin_q && nxt.mode == MODE_BOOST) begin
      nxt.mode = MODE_OFF;
    end

    // Safety timeouts override any mode change this cycle
    if (boost_now && st_ff.ms_cnt >= BOOST_LIM) begin
      nxt.mode = MODE_OFF;
      e3[0]    = 1'b1;
    end
    if (st_ff.mode[1] && st_ff.ms_cnt >= CHARGE_LIM) begin
      nxt.mode = MODE_OFF;
      e2[0]    = 1'b1;
    end

    // Thermal hold releases only once the die has cooled
    if (sense.thermal_trip) begin
      nxt.therm_hold = 1'b1;
    end else if (sense.thermal_clear) begin
      nxt.therm_hold = 1'b0;
    end
    e1[1] = rise.thermal_trip;
    e1[0] = rise.vbus_ovp;
    e2[1] = rise.reverse;
    e2[3] = rise.bat_ovp;

    // Sag must persist before it is flagged; removal is brief
    if (!sense.sag_loop) begin
      nxt.sag_cnt = '0;
    end else if (st_ff.tick && st_ff.sag_cnt <= SAG_LIM) begin
      nxt.sag_cnt = st_ff.sag_cnt + 1'b1;
    end
    e2[2] = sense.sag_loop & st_ff.tick & (st_ff.sag_cnt == SAG_LIM);

    // Boost protections
    if (boost_now && rise.boost_ovp) begin
      nxt.mode     = MODE_OFF;
      nxt.ovp_lock = 1'b1;
      e3[1]        = 1'b1;
    end
    if (!(boost_now && sense.overload)) begin
      nxt.ol_cnt = '0;
    end else if (st_ff.tick && st_ff.ol_cnt <= OL_LIM) begin
      nxt.ol_cnt = st_ff.ol_cnt + 1'b1;
    end
    if (boost_now && sense.overload && st_ff.tick &&
        st_ff.ol_cnt == OL_LIM) begin
      nxt.mode = MODE_OFF;
      e3[2]    = 1'b1;
    end

    // Sets after read clears, so a coincident event survives
    nxt.f1 = nxt.f1 | e1;
    nxt.f2 = nxt.f2 | e2;
    nxt.f3 = nxt.f3 | e3;

    // Interrupt latch; masks never touch flags or responses
    if (acc_flt) begin
      nxt.int_pend = 1'b0;
    end
    if (|(e1 & ~st_ff.m1) || |(e2 & ~st_ff.m2) || |(e3 & ~st_ff.m3)) begin
      nxt.int_pend = 1'b1;
    end
    nxt.int_oe_n = ~nxt.int_pend;

    // Timer restarts on any command and idles while the mode is off
    if (nxt.mode == MODE_OFF || bus_cmd) begin
      nxt.ms_cnt = '0;
    end else if (st_ff.tick && st_ff.ms_cnt != MS_MAX) begin
      nxt.ms_cnt = st_ff.ms_cnt + 1'b1;
    end

    // Power path decode
    nxt.pwr = '0;
    case (nxt.mode)
      MODE_OFF: begin
        nxt.pwr.hiz = 1'b1;
      end
      MODE_BOOST: begin
        nxt.pwr.hiz      = nxt.therm_hold;
        nxt.pwr.boost_on = ~nxt.therm_hold;
      end
      MODE_CHARGE, MODE_CHARGE_T: begin
        nxt.pwr.hiz       = nxt.therm_hold | sense.reverse |
                            sense.bat_ovp;
        nxt.pwr.charge_on = ~nxt.pwr.hiz & ~sense.vbus_ovp;
      end
      default: begin
        nxt.pwr.hiz = 1'b1;
      end
    endcase
    nxt.pwr.blocking_on  = ~nxt.pwr.hiz;
    nxt.pwr.converter_on = nxt.pwr.boost_on | nxt.pwr.charge_on;

    // Pulse skipping trades ripple for light-load efficiency
    if (!nxt.pwr.boost_on || sense.node_low) begin
      nxt.skip = 1'b0;
    end else if (sense.ind_low) begin
      nxt.skip = 1'b1;
    end
    nxt.pwr.switching      = nxt.pwr.converter_on & ~nxt.skip;
    nxt.pwr.short_charge   = nxt.pwr.charge_on & sense.bat_short;
    nxt.pwr.reduced_charge = nxt.cfg[`CFG_REDUCED];

    // Status pin behaviour
    case (nxt.stat_ctrl)
      `STAT_AUTO: nxt.stat_oe_n = ~nxt.pwr.charge_on;
      `STAT_LOW:  nxt.stat_oe_n = 1'b0;
      default:    nxt.stat_oe_n = 1'b1;
    endcase
  end

  // State register; pins start released and input in high impedance
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff           <= '0;
      st_ff.cfg       <= `RST_CONFIG;
      st_ff.int_oe_n  <= 1'b1;
      st_ff.stat_oe_n <= 1'b1;
      st_ff.pwr.hiz   <= 1'b1;
    end else begin
      st_ff <= nxt;
    end
  end

  // Outputs straight from state; open-drain data is always low
  assign axi_rsp   = st_ff.rsp;
  assign power     = st_ff.pwr;
  assign int_oe_n  = st_ff.int_oe_n;
  assign stat_oe_n = st_ff.stat_oe_n;
  assign int_out   = 1'b0;
  assign stat_out  = 1'b0;

  // Checks on the supervisor behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  boost_timeout_a: assert property (
    st_ff.mode == MODE_BOOST && st_ff.ms_cnt >= BOOST_LIM
    |=> st_ff.mode == MODE_OFF && st_ff.f3[0])
    else $error("boost timeout not taken");

  charge_timeout_a: assert property (
    st_ff.mode[1] && st_ff.ms_cnt >= CHARGE_LIM
    |=> st_ff.mode == MODE_OFF && st_ff.f2[0])
    else $error("charge timeout not taken");

  timer_restart_a: assert property (
    ar_hs |=> st_ff.ms_cnt == '0)
    else $error("timer not restarted by command");

  hiz_when_off_a: assert property (
    st_ff.mode == MODE_OFF |-> st_ff.pwr.hiz && !st_ff.pwr.converter_on)
    else $error("mode off without high impedance");

  int_has_flag_a: assert property (
    !st_ff.int_oe_n |-> (|{st_ff.f1, st_ff.f2, st_ff.f3}))
    else $error("interrupt low with no flag");

  reduced_attach_a: assert property (
    $rose(sense.source_valid) |=> st_ff.pwr.reduced_charge)
    else $error("reduced charge not set on attach");

  ovp_lockout_a: assert property (
    st_ff.ovp_lock |-> st_ff.mode != MODE_BOOST)
    else $error("boost running under lockout");

  overload_stop_a: assert property (
    st_ff.mode == MODE_BOOST && sense.overload && st_ff.tick &&
    st_ff.ol_cnt == OL_LIM
    |=> st_ff.mode == MODE_OFF && st_ff.f3[2])
    else $error("overload not stopped");

  sag_delay_a: assert property (
    st_ff.sag_cnt < SAG_LIM |=> !$rose(st_ff.f2[2]))
    else $error("sag flag set too early");

  stat_forced_a: assert property (
    st_ff.stat_ctrl == `STAT_LOW |-> !st_ff.stat_oe_n)
    else $error("status pin not forced low");

  short_charge_a: assert property (
    st_ff.pwr.short_charge |-> st_ff.pwr.charge_on)
    else $error("short charge outside charging");

  pin_disabled_a: assert property (
    !st_ff.cfg[`CFG_PIN_EN] |=> !st_ff.pin_q)
    else $error("boost pin seen while disabled");

  // Main scenarios
  boost_timeout_c: cover property (
    st_ff.mode == MODE_BOOST ##1 st_ff.f3[0]);
  charge_timeout_c: cover property (
    st_ff.mode[1] ##1 st_ff.f2[0]);
  int_fires_c: cover property (
    st_ff.int_oe_n ##1 !st_ff.int_oe_n);
  pin_boost_c: cover property (
    st_ff.mode == MODE_OFF ##1 st_ff.mode == MODE_BOOST && st_ff.pin_q);

endmodule : charger_boost_supervisor

// >>> logic/supervisor_map.svh
// Register offsets, field positions, reset values and timing counts
// for the charger and boost supervisor.
// Assumes a 10 MHz mclk and byte addresses on an AXI4-Lite bus.
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_CONFIG  8'h04
`define OFS_FAULT1  8'h08
`define OFS_FAULT2  8'h0C
`define OFS_FAULT3  8'h10
`define OFS_MASK1   8'h14
`define OFS_MASK2   8'h18
`define OFS_MASK3   8'h1C
`define OFS_STATE   8'h20

// Field positions
`define MODE_LSB    0
`define STAT_LSB    2
`define CFG_REDUCED 0
`define CFG_PIN_EN  1
`define CFG_PIN_POL 2

// Codes and reset values
`define STAT_AUTO   2'h0
`define STAT_LOW    2'h1
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define RST_CONFIG  8'h00

// Timing
`define MCLK_KHZ          10000
`define TICK_MS           1
`define TICK_W            14
`define BOOST_LIMIT_S     32
`define CHARGE_LIMIT_MIN  32
`define SAG_DELAY_MS      32
`define OVERLOAD_MS       30
`define BOOST_LIMIT_TICKS (`BOOST_LIMIT_S * 1000 / `TICK_MS)
`define CHARGE_LIMIT_TICKS (`CHARGE_LIMIT_MIN * 60000 / `TICK_MS)
`define SAG_DELAY_TICKS   (`SAG_DELAY_MS / `TICK_MS)
`define OVERLOAD_TICKS    (`OVERLOAD_MS / `TICK_MS)

`endif

// >>> logic/supervisor_pkg.sv
// Types shared by the charger and boost supervisor.
// Assumes an 8-bit AXI4-Lite byte address with 32-bit data.
package supervisor_pkg;
  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_BOOST    = 2'b01,
    MODE_CHARGE   = 2'b10,
    MODE_CHARGE_T = 2'b11
  } op_mode_e;

  typedef logic [13:0] tick_t;
  typedef logic [20:0] ms_t;
  typedef logic [5:0]  cnt_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic thermal_trip;
    logic thermal_clear;
    logic vbus_ovp;
    logic reverse;
    logic sag_loop;
    logic source_valid;
    logic bat_ovp;
    logic bat_short;
    logic boost_ovp;
    logic overload;
    logic ind_low;
    logic node_low;
  } sense_s;

  typedef struct packed {
    logic hiz;
    logic blocking_on;
    logic converter_on;
    logic boost_on;
    logic charge_on;
    logic short_charge;
    logic switching;
    logic reduced_charge;
  } power_s;

  typedef struct packed {
    axi_rsp_s    rsp;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    op_mode_e    mode;
    logic [1:0]  stat_ctrl;
    logic [7:0]  cfg;
    logic [1:0]  f1;
    logic [3:0]  f2;
    logic [2:0]  f3;
    logic [1:0]  m1;
    logic [3:0]  m2;
    logic [2:0]  m3;
    logic        int_pend;
    sense_s      sense_q;
    logic        pin_q;
    tick_t       tick_cnt;
    logic        tick;
    ms_t         ms_cnt;
    cnt_t        sag_cnt;
    cnt_t        ol_cnt;
    logic        therm_hold;
    logic        ovp_lock;
    logic        skip;
    power_s      pwr;
    logic        int_oe_n;
    logic        stat_oe_n;
  } st_s;
endpackage : supervisor_pkg

// >>> bench/axi_host_model.sv
// Host processor model: AXI4-Lite master moving one word at a time.
// Assumes a slave that answers; the bench watchdog ends any hang.
`timescale 1ns/1ns
module axi_host_model (
  // Clock
  input  wire logic                     mclk,
  // Register bus
  output      supervisor_pkg::axi_req_s req,
  input  wire supervisor_pkg::axi_rsp_s rsp
);
  import supervisor_pkg::*;

  // Bus idle from time zero
  initial req = '0;

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge mclk);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    do begin
      @(posedge mclk);
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  // Read: rready held from the start so the answer is taken at once
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar;
    @(posedge mclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    ar = 1'b1;
    do begin
      @(posedge mclk);
      if (ar && rsp.arready) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
endmodule : axi_host_model

// >>> bench/charger_boost_supervisor_tb.sv
// Self-checking bench for the charger and boost supervisor.
// Assumes the host model for bus traffic; TICK_CYCLES shrunk to 2.
`timescale 1ns/1ns
`include "supervisor_map.svh"
module charger_boost_supervisor_tb;
  import supervisor_pkg::*;
  localparam int TICK = 2;
  logic        mclk;
  logic        rst;
  axi_req_s    axi_req;
  axi_rsp_s    axi_rsp;
  sense_s      sense;
  logic        boost_request_pin;
  power_s      power;
  logic        int_oe_n;
  logic        stat_oe_n;
  int          failures;
  int          n_compared;
  int          m_mode;
  int          m_cfg;
  int          n;
  logic [7:0]  rnd;
  logic [31:0] rdat;
  logic [1:0]  resp;

  charger_boost_supervisor #(.TICK_CYCLES(TICK)) i_dut (
    .mclk(mclk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .sense(sense), .boost_request_pin(boost_request_pin), .power(power),
    .int_out(), .int_oe_n(int_oe_n), .stat_out(), .stat_oe_n(stat_oe_n));

  axi_host_model i_host (.mclk(mclk), .req(axi_req), .rsp(axi_rsp));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Random source, seeded at 41 so every run is identical
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bus helpers keep the model registers in step with every write
  task automatic wm(input logic [7:0] a, input logic [31:0] d);
    i_host.wr(a, d, resp);
    chk(resp, `RESP_OKAY);
    if (a == `OFS_CONTROL) m_mode = d[1:0];
    if (a == `OFS_CONFIG) m_cfg = d[7:0];
  endtask : wm

  task automatic rm(input logic [7:0] a, input logic [31:0] msk);
    i_host.rd(a, rdat, resp);
    rdat = rdat & msk;
  endtask : rm

  // Counts edges until the interrupt pin is pulled, capped by lim
  task automatic wait_int(input int lim);
    n = 0;
    while (int_oe_n !== 1'b0 && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_int

  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Watchdog sized for the boost timeout plus the short scenarios
  initial begin
    repeat (95000) @(posedge mclk);
    failures++;
    complete_run;
  end

  initial begin
    rst = 1'b1;
    sense = '0;
    boost_request_pin = 1'b0;
    failures = 0;
    n_compared = 0;
    m_mode = 0;
    m_cfg = 0;
    rnd = 8'h29;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // Reset values of every place, then an unmapped one both ways
    for (int a = 0; a < 9; a++) begin
      rm(8'(a * 4), 32'hffff_ffff);
      chk(rdat, (a == 8) ? 32'h80 : 32'h0);
    end
    rm(8'h24, 32'hffff_ffff);
    chk(resp, `RESP_SLVERR);
    chk(rdat, 32'h0);
    i_host.wr(8'h24, 32'h1, resp);
    chk(resp, `RESP_SLVERR);
    // Every mode code, with status pin settings 0, 1, 2 and 0 in turn
    for (int m = 0; m < 4; m++) begin
      wm(`OFS_CONTROL, 32'(m | ((m % 3) << 2)));
      rm(`OFS_STATE, 32'h98);
      chk(rdat, {24'h0, m == 0, 2'b00, m == 1, m >= 2, 3'b000});
      chk(32'(power) & 32'h98, rdat);
      chk(stat_oe_n, (m % 3 == 1) ? 0 : (m % 3 == 2) ? 1 : m < 2);
    end
    // Spare configuration bits carry a random pattern through faults
    rnd = lfsr(rnd);
    wm(`OFS_CONFIG, {24'h0, rnd[7:3], 3'b000});
    rm(`OFS_CONFIG, 32'hff);
    chk(rdat, m_cfg);
    // Input overvoltage while charging, read clear, then masked
    @(posedge mclk);
    sense.vbus_ovp <= 1'b1;
    wait_int(10);
    chk(int_oe_n, 1'b0);
    rm(`OFS_STATE, 32'h28);
    chk(rdat, 32'h0);
    rm(`OFS_FAULT1, 32'h3);
    chk(rdat, 32'h1);
    chk(int_oe_n, 1'b1);
    rm(`OFS_FAULT1, 32'h3);
    chk(rdat, 32'h0);
    wm(`OFS_MASK1, 32'h1);
    @(posedge mclk);
    sense.vbus_ovp <= 1'b0;
    @(posedge mclk);
    sense.vbus_ovp <= 1'b1;
    wait_int(10);
    chk(int_oe_n, 1'b1);
    rm(`OFS_FAULT1, 32'h3);
    chk(rdat, 32'h1);
    sense.vbus_ovp <= 1'b0;
    rm(`OFS_STATE, 32'h08);
    chk(rdat, 32'h08);
    wm(`OFS_MASK1, 32'h0);
    // Thermal trip holds high impedance until the die has cooled
    @(posedge mclk);
    sense.thermal_trip <= 1'b1;
    rm(`OFS_STATE, 32'h488);
    chk(rdat, 32'h480);
    sense.thermal_trip <= 1'b0;
    rm(`OFS_STATE, 32'h488);
    chk(rdat, 32'h480);
    sense.thermal_clear <= 1'b1;
    rm(`OFS_STATE, 32'h488);
    chk(rdat, 32'h08);
    sense.thermal_clear <= 1'b0;
    rm(`OFS_FAULT1, 32'h3);
    chk(rdat, 32'h2);
    // Reverse current and battery overvoltage, each released again
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      if (k == 0) sense.reverse <= 1'b1;
      else sense.bat_ovp <= 1'b1;
      rm(`OFS_STATE, 32'he8);
      chk(rdat, 32'h80);
      rm(`OFS_FAULT2, 32'hf);
      chk(rdat, (k == 0) ? 32'h2 : 32'h8);
      sense <= '0;
      rm(`OFS_STATE, 32'h88);
      chk(rdat, 32'h08);
    end
    @(posedge mclk);
    sense.bat_short <= 1'b1;
    rm(`OFS_STATE, 32'h0c);
    chk(rdat, 32'h0c);
    // Sag flag only after the loop has held for 32 ticks
    sense.bat_short <= 1'b0;
    sense.sag_loop <= 1'b1;
    wait_int(200);
    chk(n >= 62 && n <= 72, 1);
    rm(`OFS_FAULT2, 32'hf);
    chk(rdat, 32'h4);
    // Source attach sets the reduced charge bit, host clears it
    sense <= '0;
    @(posedge mclk);
    sense.source_valid <= 1'b1;
    rm(`OFS_CONFIG, 32'h1);
    chk(rdat, 32'h1);
    wm(`OFS_CONFIG, m_cfg);
    rm(`OFS_CONFIG, 32'hff);
    chk(rdat, m_cfg);
    // Boost request pin: ignored until enabled, then both polarities
    wm(`OFS_CONTROL, 32'h0);
    @(posedge mclk);
    boost_request_pin <= 1'b1;
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h0);
    wm(`OFS_CONFIG, m_cfg | 6);
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h1);
    boost_request_pin <= 1'b0;
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h0);
    wm(`OFS_CONFIG, m_cfg & 32'hfb);
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h1);
    wm(`OFS_CONFIG, m_cfg & 32'hf9);
    // Dropping the enable ends a pin-started boost, so restart by host
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h0);
    wm(`OFS_CONTROL, 32'h1);
    // Overload must persist past 30 ticks before boost stops
    @(posedge mclk);
    sense.overload <= 1'b1;
    wait_int(200);
    chk(n >= 58 && n <= 70, 1);
    sense.overload <= 1'b0;
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h0);
    // A fault register write releases the pin but keeps the flag
    wm(`OFS_FAULT3, 32'h0);
    chk(int_oe_n, 1'b1);
    rm(`OFS_FAULT3, 32'h7);
    chk(rdat, 32'h4);
    // Boost overvoltage locks out until the host writes boost again
    wm(`OFS_CONTROL, 32'h1);
    @(posedge mclk);
    sense.boost_ovp <= 1'b1;
    rm(`OFS_STATE, 32'h290);
    chk(rdat, 32'h280);
    sense.boost_ovp <= 1'b0;
    rm(`OFS_FAULT3, 32'h7);
    chk(rdat, 32'h2);
    wm(`OFS_CONTROL, 32'h1);
    rm(`OFS_STATE, 32'h210);
    chk(rdat, 32'h10);
    // Light load skips pulses until the output node droops
    sense.ind_low <= 1'b1;
    rm(`OFS_STATE, 32'h112);
    chk(rdat, 32'h110);
    sense.ind_low <= 1'b0;
    sense.node_low <= 1'b1;
    rm(`OFS_STATE, 32'h112);
    chk(rdat, 32'h12);
    sense.node_low <= 1'b0;
    // Boost timeout, the count restarted by a read partway through
    repeat (10000) @(posedge mclk);
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, 32'h1);
    wait_int(70000);
    chk(n >= 63900 && n <= 64100, 1);
    m_mode = 0;
    rm(`OFS_CONTROL, 32'h3);
    chk(rdat, m_mode);
    rm(`OFS_CONFIG, 32'hff);
    chk(rdat, m_cfg);
    rm(`OFS_FAULT3, 32'h7);
    chk(rdat, 32'h1);
    rm(`OFS_FAULT3, 32'h7);
    chk(rdat, 32'h0);
    rm(`OFS_STATE, 32'h90);
    chk(rdat, 32'h80);
    complete_run;
  end
endmodule : charger_boost_supervisor_tb
